// [rtl/dpf_dev_end.sv]
`timescale 1ns/1ps
`include "dpf_defines.svh"
module dpf_dev_end #(
  parameter int LANES = 4,
  parameter int BOUND_DEFAULT = 32'h0001_0000
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  dpf_if.dev port,
  input wire logic [31:0] bound_i,
  input wire logic acc_ready_i,
  output logic acc_valid_o,
  output logic [LANES-1:0] acc_lane_en_o,
  output logic [LANES*32-1:0] acc_addr_o,
  output logic [LANES-1:0] acc_oob_o,
  output logic [LANES*4-1:0] acc_slot_o,
  output logic [LANES*4-1:0] acc_elem_o,
  output logic acc_write_o,
  output logic msg_busy_o,
  output logic msg_done_o,
  output logic msg_reject_o
);
  localparam int STEPS = `DPF_MAX_SLOTS * `DPF_MAX_ELEMS / LANES;

  // Lane count must tile the whole slot-by-element grid
  if (LANES < 1 || LANES > 16 || (`DPF_MAX_SLOTS * `DPF_MAX_ELEMS) % LANES != 0)
  begin : g_lanes_check
    $error("LANES must divide 256 and lie in 1..16");
  end

  typedef enum {DPF_IDLE, DPF_RUN} dpf_state_type;
  dpf_state_type state;
  dpf_state_type next_state;

  // Captured message
  logic [15:0] mask_q;
  logic [16*32-1:0] off_q;
  logic [16*32-1:0] y_q;
  logic [16*32-1:0] z_q;
  logic [31:0] base_q;
  logic [31:0] pitch_q;
  logic [31:0] spitch_q;
  logic [4:0] nslots_q;
  logic [4:0] elems_q;
  logic [2:0] ebl_q;
  logic typed_q;
  logic write_q;
  dpf_pkg::dpf_surf_type surf_q;
  dpf_pkg::dpf_simd_type simd_q;
  logic [7:0] step;
  logic legal;
  logic [4:0] nslots;
  logic [15:0] eff_mask;
  logic [15:0] payload_bytes;

  // Slot count from the message width
  function automatic logic [4:0] slot_count(input dpf_pkg::dpf_simd_type s);
    case (s)
      dpf_pkg::DPF_SLOTS_1: slot_count = 5'd1;
      dpf_pkg::DPF_SLOTS_2: slot_count = 5'd2;
      dpf_pkg::DPF_SLOTS_8: slot_count = 5'd8;
      default: slot_count = 5'd16;
    endcase
  endfunction

  // Compressible read format filter
  function automatic logic fmt_ok(input logic [8:0] f);
    fmt_ok = (f == `DPF_FMT_SINGLE_8BIT_UNSIGNED_NORM) || (f == `DPF_FMT_SINGLE_8BIT_UNSIGNED_INT)
      || (f == `DPF_FMT_ALPHA_8BIT_UNSIGNED_NORM);
  endfunction

  // Effective mask per semantics; group takes the byte picked by slot_group, SIMD eight-wide drops the high byte
  always_comb
  begin
    eff_mask = port.exec_mask;
    if (port.masksem == dpf_pkg::DPF_MS_GROUP)
      eff_mask = port.slot_group ? {8'h00, port.exec_mask[15:8]}
        : {8'h00, port.exec_mask[7:0]};
    else if (port.simd == dpf_pkg::DPF_SLOTS_8 && port.masksem == dpf_pkg::DPF_MS_SIMD)
      eff_mask = {8'h00, port.exec_mask[7:0]};
  end

  assign nslots = slot_count(port.simd);
  assign payload_bytes = 16'(nslots) * 16'(port.elems) * (16'h0001 << port.elem_bytes_log2);
  // Oversized payloads and unsupported compressible formats are refused
  assign legal = (payload_bytes <= 16'(`DPF_MAX_PAYLOAD_BYTES))
    && port.elems != 5'd0 && port.elems <= 5'(`DPF_MAX_ELEMS)
    && !(port.compressible && (port.is_write || !fmt_ok(port.fmt)))
    && !(port.typed && port.simd == dpf_pkg::DPF_SLOTS_16);

  assign port.req_ready = ce_i && state == DPF_IDLE;

  always_comb
  begin
    next_state = state;
    case (state)
      DPF_IDLE:
        if (port.req_valid && legal)
          next_state = DPF_RUN;
      DPF_RUN:
        if (acc_ready_i && {1'b0, step} == 9'(STEPS - 1))
          next_state = DPF_IDLE;
      default:
        next_state = DPF_IDLE;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      state <= DPF_IDLE;
    else if (ce_i)
      state <= next_state;
  end

  // Capture everything at acceptance so later port changes have no effect
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      mask_q <= 16'h0000;
      off_q <= '0;
      y_q <= '0;
      z_q <= '0;
      base_q <= 32'h0000_0000;
      pitch_q <= 32'h0000_0000;
      spitch_q <= 32'h0000_0000;
      nslots_q <= 5'h00;
      elems_q <= 5'h00;
      ebl_q <= 3'h0;
      typed_q <= 1'b0;
      write_q <= 1'b0;
      surf_q <= dpf_pkg::DPF_ST_1D;
      simd_q <= dpf_pkg::DPF_SLOTS_1;
    end
    else if (ce_i && state == DPF_IDLE && port.req_valid && legal)
    begin
      mask_q <= eff_mask;
      off_q <= port.offsets;
      y_q <= port.coord_y;
      z_q <= port.coord_z;
      // Only untyped flat 32-bit messages carry a usable header base
      base_q <= (port.model == dpf_pkg::DPF_FLAT_32BIT_ADDRESSING && !port.typed)
        ? port.hdr_base : 32'h0000_0000;
      pitch_q <= port.pitch;
      spitch_q <= port.slice_pitch;
      nslots_q <= nslots;
      elems_q <= port.elems;
      ebl_q <= port.elem_bytes_log2;
      typed_q <= port.typed;
      write_q <= port.is_write;
      surf_q <= port.surf;
      simd_q <= port.simd;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      step <= 8'h00;
    else if (ce_i)
    begin
      if (state == DPF_IDLE)
        step <= 8'h00;
      else if (acc_ready_i)
        step <= step + 8'h01;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      msg_done_o <= 1'b0;
      msg_reject_o <= 1'b0;
    end
    else if (ce_i)
    begin
      msg_done_o <= state == DPF_RUN && next_state == DPF_IDLE;
      msg_reject_o <= state == DPF_IDLE && port.req_valid && !legal;
    end
  end

  assign msg_busy_o = state == DPF_RUN;
  assign acc_write_o = write_q;
  assign acc_valid_o = ce_i && state == DPF_RUN && |acc_lane_en_o;

  // LANES accesses go out per step, in parallel; slot-major, element-minor walk
  genvar g;
  generate
    for (g = 0; g < LANES; g++)
    begin : g_lane
      logic [7:0] idx;
      logic [3:0] sl;
      logic [3:0] el;
      logic [31:0] slot_off;
      logic [31:0] addr;
      assign idx = 8'(int'(step) * LANES + g);
      assign sl = idx[7:4];
      assign el = idx[3:0];
      // Typed: surface type picks components; untyped: one linear offset
      always_comb
      begin
        slot_off = off_q[32*sl +: 32];
        if (typed_q)
        begin
          case (surf_q)
            dpf_pkg::DPF_ST_2D: slot_off = off_q[32*sl +: 32]
              + y_q[32*sl +: 32] * pitch_q;
            dpf_pkg::DPF_ST_3D: slot_off = off_q[32*sl +: 32]
              + y_q[32*sl +: 32] * pitch_q + z_q[32*sl +: 32] * spitch_q;
            default: slot_off = off_q[32*sl +: 32];
          endcase
        end
      end
      // Each slot offset, at every width, bases a run of consecutive elements
      assign addr = base_q + slot_off + (32'(el) << ebl_q);
      // Slot bit gates all its elements; writes may overlap unordered
      assign acc_lane_en_o[g] = {1'b0, sl} < nslots_q && {1'b0, el} < elems_q
        && mask_q[sl];
      assign acc_addr_o[32*g +: 32] = addr;
      assign acc_oob_o[g] = addr >= bound_i;
      assign acc_slot_o[4*g +: 4] = sl;
      assign acc_elem_o[4*g +: 4] = el;
    end
  endgenerate
endmodule

// [include/dpf_defines.svh]
`ifndef DPF_DEFINES_SVH
`define DPF_DEFINES_SVH
// Surface format codes accepted by compressible media block reads
`define DPF_FMT_SINGLE_8BIT_UNSIGNED_NORM 9'h140
`define DPF_FMT_SINGLE_8BIT_UNSIGNED_INT 9'h143
`define DPF_FMT_ALPHA_8BIT_UNSIGNED_NORM 9'h144
// Message geometry
`define DPF_MASK_W 16
`define DPF_MAX_SLOTS 16
`define DPF_HALF_SLOTS 8
`define DPF_MAX_PAYLOAD_BYTES 256
`define DPF_MAX_ELEMS 16
`endif

// [include/dpf_pkg.sv]
package dpf_pkg;
  // Number of slots carried by a message
  typedef enum logic [1:0] {DPF_SLOTS_1, DPF_SLOTS_2, DPF_SLOTS_8, DPF_SLOTS_16} dpf_simd_type;
  // Address model selected by the message
  typedef enum logic [1:0] {DPF_BINDING_TABLE_SURFACE_MODEL, DPF_SHARED_LOCAL_MEMORY,
    DPF_FLAT_32BIT_ADDRESSING, DPF_FLAT_64BIT_ADDRESSING} dpf_model_type;
  // Mask semantics: normal SIMD, slot group, block
  typedef enum logic [1:0] {DPF_MS_SIMD, DPF_MS_GROUP, DPF_MS_BLOCK} dpf_masksem_type;
  // Surface kind for typed messages
  typedef enum logic [1:0] {DPF_ST_1D, DPF_ST_2D, DPF_ST_3D} dpf_surf_type;
endpackage

// [include/dpf_if.sv]
`timescale 1ns/1ps
interface dpf_if;
  logic req_valid;
  logic req_ready;
  dpf_pkg::dpf_simd_type simd;
  dpf_pkg::dpf_model_type model;
  dpf_pkg::dpf_masksem_type masksem;
  dpf_pkg::dpf_surf_type surf;
  logic typed;
  logic is_write;
  logic slot_group;
  logic compressible;
  logic [8:0] fmt;
  logic [15:0] exec_mask;
  logic [31:0] hdr_base;
  logic [4:0] elems;
  logic [2:0] elem_bytes_log2;
  logic [16*32-1:0] offsets;
  logic [16*32-1:0] coord_y;
  logic [16*32-1:0] coord_z;
  logic [31:0] pitch;
  logic [31:0] slice_pitch;
  modport dev (input req_valid, output req_ready, input simd, input model, input masksem,
    input surf, input typed, input is_write, input slot_group, input compressible, input fmt,
    input exec_mask, input hdr_base, input elems, input elem_bytes_log2, input offsets,
    input coord_y, input coord_z, input pitch, input slice_pitch);
  modport eu (output req_valid, input req_ready, output simd, output model, output masksem,
    output surf, output typed, output is_write, output slot_group, output compressible,
    output fmt, output exec_mask, output hdr_base, output elems, output elem_bytes_log2,
    output offsets, output coord_y, output coord_z, output pitch, output slice_pitch);
endinterface

// [rtl/dpf_eu_end.sv]
`timescale 1ns/1ps
`include "dpf_defines.svh"
// Issuer end: turns user sends into port messages
module dpf_eu_end (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  dpf_if.eu port,
  input wire logic send_i,
  output logic send_ready_o,
  output logic send_dropped_o,
  input wire dpf_pkg::dpf_simd_type simd_i,
  input wire dpf_pkg::dpf_model_type model_i,
  input wire dpf_pkg::dpf_masksem_type masksem_i,
  input wire dpf_pkg::dpf_surf_type surf_i,
  input wire logic typed_i,
  input wire logic is_write_i,
  input wire logic compressible_i,
  input wire logic [8:0] fmt_i,
  input wire logic [15:0] exec_mask_i,
  input wire logic [31:0] hdr_base_i,
  input wire logic [4:0] elems_i,
  input wire logic [2:0] elem_bytes_log2_i,
  input wire logic [16*32-1:0] offsets_i,
  input wire logic [16*32-1:0] coord_y_i,
  input wire logic [16*32-1:0] coord_z_i,
  input wire logic [31:0] pitch_i,
  input wire logic [31:0] slice_pitch_i
);
  logic busy;
  logic second;
  logic split;
  logic [15:0] m_mask;
  assign split = typed_i && (simd_i == dpf_pkg::DPF_SLOTS_16);
  // A split send counts as taken only with its upper half, so the user holds it until then
  assign send_ready_o = ce_i && (busy ? (second && port.req_ready)
    : (exec_mask_i == 16'h0000 || (!split && port.req_ready)));

  // Typed 16-wide sends go out as two slot-group halves
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      busy <= 1'b0;
      second <= 1'b0;
    end
    else if (ce_i)
    begin
      if (!busy && send_i && split && exec_mask_i != 16'h0000)
      begin
        busy <= 1'b1;
        second <= 1'b0;
      end
      else if (busy && port.req_ready)
      begin
        if (second)
          busy <= 1'b0;
        second <= !second;
      end
    end
  end

  // An all-clear mask never reaches the port
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      send_dropped_o <= 1'b0;
    else if (ce_i)
      send_dropped_o <= send_i && !busy && exec_mask_i == 16'h0000;
  end

  always_comb
  begin
    m_mask = exec_mask_i;
  end

  assign port.req_valid = ce_i && exec_mask_i != 16'h0000
    && (busy || (send_i && !split));
  assign port.simd = busy ? dpf_pkg::DPF_SLOTS_8 : simd_i;
  assign port.masksem = busy ? dpf_pkg::DPF_MS_GROUP : masksem_i;
  assign port.slot_group = busy ? second : 1'b0;
  assign port.offsets = (busy && second) ? {256'h0, offsets_i[16*32-1:8*32]} : offsets_i;
  assign port.coord_y = (busy && second) ? {256'h0, coord_y_i[16*32-1:8*32]} : coord_y_i;
  assign port.coord_z = (busy && second) ? {256'h0, coord_z_i[16*32-1:8*32]} : coord_z_i;
  assign port.model = model_i;
  assign port.surf = surf_i;
  assign port.typed = typed_i;
  assign port.is_write = is_write_i;
  assign port.compressible = compressible_i;
  assign port.fmt = fmt_i;
  assign port.exec_mask = m_mask;
  assign port.hdr_base = hdr_base_i;
  assign port.elems = elems_i;
  assign port.elem_bytes_log2 = elem_bytes_log2_i;
  assign port.pitch = pitch_i;
  assign port.slice_pitch = slice_pitch_i;
endmodule

// [tb/dpf_assertions.sv]
`timescale 1ns/1ps
// Watches the issuer side of the message port
module dpf_assertions (
  input logic clk_i,
  input logic sys_rst_i,
  input logic req_valid,
  input logic req_ready,
  input dpf_pkg::dpf_simd_type simd,
  input dpf_pkg::dpf_model_type model,
  input dpf_pkg::dpf_masksem_type masksem,
  input logic typed,
  input logic slot_group,
  input logic [15:0] exec_mask,
  input logic [16*32-1:0] offsets
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // An all-clear mask must never reach the port
  property p_mask_nz;
    req_valid |-> exec_mask != 16'h0000;
  endproperty
  a_mask_nz: assert property (p_mask_nz) else $error("zero mask sent");
  // Typed traffic never travels sixteen-wide
  property p_no_t16;
    req_valid && typed |-> simd != dpf_pkg::DPF_SLOTS_16;
  endproperty
  a_no_t16: assert property (p_no_t16) else $error("typed sixteen-wide sent");
  // Group semantics only make sense with eight slots
  property p_grp8;
    req_valid && masksem == dpf_pkg::DPF_MS_GROUP |-> simd == dpf_pkg::DPF_SLOTS_8;
  endproperty
  a_grp8: assert property (p_grp8) else $error("group with wrong width");
  // Upper half is always a typed group message
  property p_hi;
    req_valid && slot_group |-> typed && masksem == dpf_pkg::DPF_MS_GROUP;
  endproperty
  a_hi: assert property (p_hi) else $error("bad upper half");
  // Lower half taken means the upper half follows within a bounded wait
  property p_pair;
    req_valid && req_ready && typed && !slot_group && masksem == dpf_pkg::DPF_MS_GROUP
      |-> ##[1:1000] req_valid && slot_group;
  endproperty
  a_pair: assert property (p_pair) else $error("upper half missing");
  // Typed messages use the surface model
  property p_bts;
    req_valid && typed |-> model == dpf_pkg::DPF_BINDING_TABLE_SURFACE_MODEL;
  endproperty
  a_bts: assert property (p_bts) else $error("typed without surface model");
  // A waiting request keeps its mask
  property p_hold_mask;
    req_valid && !req_ready |=> req_valid && $stable(exec_mask);
  endproperty
  a_hold_mask: assert property (p_hold_mask) else $error("mask moved while waiting");
  // A waiting request keeps its slot offsets and width
  property p_hold_addr;
    req_valid && !req_ready |=> $stable(offsets) && $stable(simd) && $stable(slot_group);
  endproperty
  a_hold_addr: assert property (p_hold_addr) else $error("offsets moved while waiting");
endmodule

// [tb/data_port_slot_mask_frontend_test.sv]
`timescale 1ns/1ps
module data_port_slot_mask_frontend_test;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic send_i = 1'b0;
  logic send_ready_o, send_dropped_o, acc_valid_o, acc_write_o, msg_busy_o, msg_done_o;
  logic msg_reject_o, rej, seen;
  logic typed_i = 1'b0, is_write_i = 1'b0, compressible_i = 1'b0, acc_ready_i = 1'b1;
  dpf_pkg::dpf_simd_type simd_i = dpf_pkg::DPF_SLOTS_8;
  dpf_pkg::dpf_model_type model_i = dpf_pkg::DPF_FLAT_32BIT_ADDRESSING;
  dpf_pkg::dpf_masksem_type masksem_i = dpf_pkg::DPF_MS_SIMD;
  dpf_pkg::dpf_surf_type surf_i = dpf_pkg::DPF_ST_2D;
  logic [8:0] fmt_i = 9'h140;
  logic [15:0] exec_mask_i = 16'h0001, exp_mask;
  logic [31:0] hdr_base_i = '0, pitch_i = 32'h0000_0040, slice_pitch_i = 32'h0000_1000;
  logic [31:0] bound_i = 32'hffff_ffff;
  logic [4:0] elems_i = 5'h01;
  logic [2:0] elem_bytes_log2_i = 3'h0;
  logic [511:0] offsets_i = '0, coord_y_i = '0, coord_z_i = '0;
  logic [3:0] acc_lane_en_o, acc_oob_o;
  logic [127:0] acc_addr_o;
  logic [15:0] acc_slot_o, acc_elem_o;
  logic [8:0] cfmt [6] = '{9'h140, 9'h143, 9'h144, 9'h141, 9'h106, 9'h0c0};
  int n_mismatch = 0, samples_checked = 0, n_en = 0, cyc = 0, n_done = 0;
  dpf_if port ();
  dpf_eu_end i_dpf_eu_end (.clk_i, .sys_rst_i, .ce_i, .port(port), .send_i, .send_ready_o,
    .send_dropped_o, .simd_i, .model_i, .masksem_i, .surf_i, .typed_i, .is_write_i,
    .compressible_i, .fmt_i, .exec_mask_i, .hdr_base_i, .elems_i, .elem_bytes_log2_i,
    .offsets_i, .coord_y_i, .coord_z_i, .pitch_i, .slice_pitch_i);
  dpf_dev_end #(.LANES(4)) i_dpf_dev_end (.clk_i, .sys_rst_i, .ce_i, .port(port), .bound_i,
    .acc_ready_i, .acc_valid_o, .acc_lane_en_o, .acc_addr_o, .acc_oob_o, .acc_slot_o,
    .acc_elem_o, .acc_write_o, .msg_busy_o, .msg_done_o, .msg_reject_o);
  dpf_assertions i_dpf_assertions (.clk_i, .sys_rst_i, .req_valid(port.req_valid),
    .req_ready(port.req_ready), .simd(port.simd), .model(port.model),
    .masksem(port.masksem), .typed(port.typed), .slot_group(port.slot_group),
    .exec_mask(port.exec_mask), .offsets(port.offsets));
  initial
    forever #50 clk_i = ~clk_i;
  task automatic chk(input logic [31:0] seen_v, input logic [31:0] exp_v);
    samples_checked++;
    if (seen_v !== exp_v)
    begin
      n_mismatch++;
      $display("Error at %0t: saw %h expected %h", $time, seen_v, exp_v);
    end
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  function automatic int nslots();
    return simd_i == dpf_pkg::DPF_SLOTS_1 ? 1 : simd_i == dpf_pkg::DPF_SLOTS_2 ? 2
      : simd_i == dpf_pkg::DPF_SLOTS_8 ? 8 : 16;
  endfunction
  // Enabled accesses expected: active slots times elements per slot
  function automatic int exp_cnt();
    int c = 0;
    for (int s = 0; s < 16; s++)
      c += ((typed_i || s < nslots()) && exp_mask[s]) ? int'(elems_i) : 0;
    return c;
  endfunction
  // Header base counts only for untyped flat 32-bit; typed 2D adds a row term, typed 3D adds row and slice terms
  function automatic logic [31:0] exp_addr(input int s, input int e);
    logic [31:0] b;
    b = (model_i == dpf_pkg::DPF_FLAT_32BIT_ADDRESSING && !typed_i) ? hdr_base_i
      : 32'h0000_0000;
    b += offsets_i[32*s+:32];
    if (typed_i && surf_i != dpf_pkg::DPF_ST_1D)
      b += coord_y_i[32*s+:32] * pitch_i;
    if (typed_i && surf_i == dpf_pkg::DPF_ST_3D)
      b += coord_z_i[32*s+:32] * slice_pitch_i;
    return b + (32'(e) << elem_bytes_log2_i);
  endfunction
  // The upper typed half reports slots 0..7, so the done count lifts them by eight
  task automatic lane_chk(input int g);
    int s, e;
    logic [31:0] a;
    s = int'(acc_slot_o[4*g+:4]) + 8 * n_done;
    e = int'(acc_elem_o[4*g+:4]);
    a = exp_addr(s, e);
    chk({31'h0, s < nslots() && e < int'(elems_i) && exp_mask[s]}, 32'h0000_0001);
    chk(acc_addr_o[32*g+:32], a);
    chk({31'h0, acc_oob_o[g]}, {31'h0, a >= bound_i});
    chk({31'h0, acc_write_o}, {31'h0, is_write_i});
  endtask
  // Memory side watcher; done pulses mark the end of each half
  always @(posedge clk_i)
    if (!sys_rst_i)
    begin
      if (acc_valid_o === 1'b1 && acc_ready_i)
        for (int g = 0; g < 4; g++)
          if (acc_lane_en_o[g] === 1'b1)
          begin
            n_en++;
            lane_chk(g);
          end
      if (msg_done_o === 1'b1)
        n_done++;
    end
  // Random stalls on the memory side
  always @(negedge clk_i)
    acc_ready_i <= ($urandom % 4) != 0;
  // Hang guard, well above the expected run length
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      n_mismatch++;
      finish_test;
    end
  end
  // One message from the user side; a plain message gets its mask flipped after the take
  task automatic send(output logic r);
    int t;
    n_en = 0;
    n_done = 0;
    exp_mask = exec_mask_i;
    send_i = 1'b1;
    @(posedge clk_i);
    for (t = 0; t < 400 && send_ready_o !== 1'b1; t++) @(posedge clk_i);
    if (typed_i)
      for (t = 0; t < 400 && (port.req_valid & port.req_ready & port.slot_group) !== 1'b1; t++)
        @(posedge clk_i);
    @(negedge clk_i);
    send_i = 1'b0;
    if (!typed_i)
      exec_mask_i = ~exec_mask_i;
    for (t = 0; t < 400 && msg_done_o !== 1'b1 && msg_reject_o !== 1'b1; t++) @(posedge clk_i);
    r = msg_reject_o;
    chk({31'h0, t < 400}, 32'h0000_0001);
    repeat (2) @(negedge clk_i);
  endtask
  task automatic rand_msg;
    @(negedge clk_i);
    simd_i = dpf_pkg::dpf_simd_type'(2'($urandom % 4));
    model_i = dpf_pkg::dpf_model_type'(2'($urandom));
    elem_bytes_log2_i = 3'($urandom % 3);
    elems_i = 5'(1 + $urandom % ((256 / (nslots() << elem_bytes_log2_i)) > 16 ? 16 :
      (256 / (nslots() << elem_bytes_log2_i))));
    exec_mask_i = 16'($urandom | 1);
    is_write_i = 1'($urandom);
    hdr_base_i = 32'($urandom % 32'h0000_1000);
    bound_i = 32'h0000_0800 + 32'($urandom % 32'h0000_1000);
    for (int s = 0; s < 16; s++)
    begin
      offsets_i[32*s+:32] = 32'h0000_0100 * ($urandom % 4);
      coord_y_i[32*s+:32] = 32'($urandom % 4);
      coord_z_i[32*s+:32] = 32'($urandom % 4);
    end
  endtask
  initial
  begin
    void'($urandom(32'h0000_41eb));
    repeat (16) @(posedge clk_i);
    @(negedge clk_i);
    sys_rst_i = 1'b0;
    // Random untyped traffic with repeated offsets and stalls
    repeat (40)
    begin
      rand_msg();
      send(rej);
      chk({31'h0, rej}, 32'h0000_0000);
      chk(32'(n_en), 32'(exp_cnt()));
    end
    $display("random message test done");
    // Compressible read formats, then a compressible write
    for (int i = 0; i < 7; i++)
    begin
      rand_msg();
      compressible_i = 1'b1;
      is_write_i = (i == 6);
      fmt_i = cfmt[i % 6];
      send(rej);
      chk({31'h0, rej}, {31'h0, i >= 3});
    end
    compressible_i = 1'b0;
    $display("surface format test done");
    // Payload edge: 256 bytes passes, beyond or empty is refused
    for (int i = 0; i < 4; i++)
    begin
      rand_msg();
      simd_i = dpf_pkg::DPF_SLOTS_16;
      elems_i = (i == 2) ? 5'h00 : (i == 3) ? 5'h11 : 5'h10;
      elem_bytes_log2_i = (i == 1) ? 3'h1 : 3'h0;
      send(rej);
      chk({31'h0, rej}, {31'h0, i != 0});
      if (i == 0)
        chk(32'(n_en), 32'(exp_cnt()));
    end
    $display("payload limit test done");
    // Typed sixteen-wide goes out as two group halves, once per surface kind
    for (int k = 0; k < 3; k++)
    begin
      rand_msg();
      typed_i = 1'b1;
      model_i = dpf_pkg::DPF_BINDING_TABLE_SURFACE_MODEL;
      surf_i = dpf_pkg::dpf_surf_type'(2'(k));
      simd_i = dpf_pkg::DPF_SLOTS_16;
      elems_i = 5'h02;
      exec_mask_i = (k == 0) ? 16'ha5c3 : 16'($urandom | 1);
      send(rej);
      chk({31'h0, rej}, 32'h0000_0000);
      chk(32'(n_en), 32'(exp_cnt()));
    end
    typed_i = 1'b0;
    $display("typed split test done");
    // All-clear mask is dropped before the port
    @(negedge clk_i);
    exec_mask_i = 16'h0000;
    send_i = 1'b1;
    seen = 1'b0;
    repeat (3)
    begin
      @(posedge clk_i);
      seen |= send_dropped_o;
      chk({31'h0, port.req_valid}, 32'h0000_0000);
    end
    @(negedge clk_i);
    send_i = 1'b0;
    chk({31'h0, seen}, 32'h0000_0001);
    $display("empty mask test done");
    finish_test;
  end
endmodule
